//--- lcr_pkg.sv
package lcr_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'hc8;
    localparam logic [7:0] ADDR_STATUS = 8'hc9;
    localparam logic [7:0] ADDR_ERR = 8'hcb;
    localparam logic [7:0] ADDR_BTR = 8'hcc;
    localparam logic [7:0] ADDR_DIVL = 8'hcd;
    localparam logic [7:0] ADDR_DIVH = 8'hce;
    localparam logic [7:0] ADDR_LEN = 8'hcf;
    localparam logic [7:0] ADDR_IDR = 8'hd0;
    localparam logic [7:0] ADDR_SEL = 8'hd1;
    localparam logic [7:0] ADDR_DATA = 8'hd2;
    localparam int CTRL_LEGACY_BIT = 6;
    localparam int CTRL_UART_BIT = 5;
    localparam int STATUS_ERR_BIT = 3;
    localparam int BTR_RESYNC_BIT = 7;
    localparam int SEL_AINC_BIT = 3;
    localparam logic [5:0] BTR_SPB_RESET = 6'h20;
    localparam logic [5:0] BTR_SPB_MIN = 6'h08;
    localparam logic [3:0] LEN_MAX = 4'h8;
    localparam logic [7:0] IDR_RESET = 8'h00;

    typedef struct packed {
        logic framing;
        logic sync;
        logic parity;
        logic checksum;
        logic bit_err;
    } lcr_err_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lcr_bus_t;
endpackage : lcr_pkg

//--- lcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module lcr_regs #(
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Register port.
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Mode from the frame engine side.
    input wire logic uart_mode_i,
    // Error events, one cycle pulses.
    input wire lcr_pkg::lcr_err_t err_set_i,
    // Frame engine buffer access.
    input wire logic eng_wr_i,
    input wire logic [2:0] eng_idx_i,
    input wire logic [7:0] eng_wdata_i,
    output logic [7:0] eng_rdata_o,
    input wire logic uart_rx_valid_i,
    input wire logic [7:0] uart_rx_byte_i,
    output logic [7:0] uart_tx_byte_o,
    output logic uart_tx_load_o,
    // Configuration outputs.
    output logic error_summary_flag_o,
    output logic resync_disable_o,
    output logic [5:0] samples_per_bit_o,
    output logic [11:0] baud_divisor_o,
    output logic sample_tick_o,
    output logic [3:0] tx_response_length_o,
    output logic [3:0] rx_response_length_o,
    output logic legacy_revision_select_o,
    output logic [5:0] frame_id_field_o,
    output logic [1:0] identifier_parity_o,
    output logic [3:0] legacy_response_length_o
);
    lcr_pkg::lcr_bus_t bus;
    lcr_pkg::lcr_err_t err_q, err_d;
    logic legacy_q;
    logic [7:0] btr_q, divl_q, len_q, idr_q;
    logic [3:0] divh_q;
    logic [3:0] sel_q;
    logic [7:0] uart_rx_q, uart_tx_q;
    logic uart_tx_load_q;
    logic [7:0] rdata_q, rdata_d;
    logic [11:0] div_cnt_q;
    logic [7:0] buf_q [DEPTH];
    logic [7:0] eng_rdata_q;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    wire sel_ctrl = bus.addr == lcr_pkg::ADDR_CTRL;
    wire sel_stat = bus.addr == lcr_pkg::ADDR_STATUS;
    wire sel_err = bus.addr == lcr_pkg::ADDR_ERR;
    wire sel_btr = bus.addr == lcr_pkg::ADDR_BTR;
    wire sel_divl = bus.addr == lcr_pkg::ADDR_DIVL;
    wire sel_divh = bus.addr == lcr_pkg::ADDR_DIVH;
    wire sel_len = bus.addr == lcr_pkg::ADDR_LEN;
    wire sel_idr = bus.addr == lcr_pkg::ADDR_IDR;
    wire sel_sel = bus.addr == lcr_pkg::ADDR_SEL;
    wire sel_data = bus.addr == lcr_pkg::ADDR_DATA;
    wire data_acc = sel_data & (bus.wr | bus.rd);
    wire lin_data_acc = data_acc & ~uart_mode_i;
    wire summary = |err_q;
    // Writing one to the summary bit clears every cause; a fresh event in the same cycle survives.
    wire err_clr = bus.wr & sel_stat & bus.wdata[lcr_pkg::STATUS_ERR_BIT];
    wire [2:0] idx = sel_q[2:0];
    wire ainc = ~sel_q[lcr_pkg::SEL_AINC_BIT];
    wire [11:0] divisor = {divh_q, divl_q};
    wire [3:0] tx_raw = len_q[7:4];
    wire [3:0] rx_raw = len_q[3:0];
    wire [1:0] legacy_response_length = idr_q[5:4];
    wire [5:0] spb_wr = (bus.wdata[5:0] < lcr_pkg::BTR_SPB_MIN) ? lcr_pkg::BTR_SPB_MIN : bus.wdata[5:0];

    always_comb begin
        err_d = err_clr ? '0 : err_q;
        err_d = err_d | err_set_i;
    end

    always_comb begin
        rdata_d = 8'h00;
        case (1'b1)
            sel_ctrl: rdata_d = {1'b0, legacy_q, 6'h00};
            sel_stat: rdata_d = {4'h0, summary, 3'h0};
            sel_err: rdata_d = {3'h0, err_q};
            sel_btr: rdata_d = {btr_q[7], 1'b0, btr_q[5:0]};
            sel_divl: rdata_d = divl_q;
            sel_divh: rdata_d = {4'h0, divh_q};
            sel_len: rdata_d = len_q;
            sel_idr: rdata_d = idr_q;
            sel_sel: rdata_d = {4'h0, sel_q};
            sel_data: rdata_d = uart_mode_i ? uart_rx_q : buf_q[idx];
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            err_q <= '0;
            legacy_q <= 1'b0;
            btr_q <= {2'b00, lcr_pkg::BTR_SPB_RESET};
            divl_q <= 8'h00;
            divh_q <= 4'h0;
            len_q <= 8'h00;
            idr_q <= lcr_pkg::IDR_RESET;
            rdata_q <= 8'h00;
        end else begin
            err_q <= err_d;
            rdata_q <= bus.rd ? rdata_d : 8'h00;
            if (bus.wr && sel_ctrl) legacy_q <= bus.wdata[lcr_pkg::CTRL_LEGACY_BIT];
            if (bus.wr && sel_btr) btr_q <= {bus.wdata[lcr_pkg::BTR_RESYNC_BIT], 1'b0, spb_wr};
            if (bus.wr && sel_divl) divl_q <= bus.wdata;
            // Reserved divider bits are dropped, so a careless write cannot reach them.
            if (bus.wr && sel_divh) divh_q <= bus.wdata[3:0];
            if (bus.wr && sel_len) len_q <= bus.wdata;
            if (bus.wr && sel_idr) idr_q <= bus.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sel_q <= 4'h0;
        end else if (bus.wr && sel_sel) begin
            sel_q <= bus.wdata[3:0];
        end else if (lin_data_acc && ainc) begin
            sel_q <= {sel_q[3], idx + 3'h1};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < DEPTH; i++) buf_q[i] <= 8'h00;
            eng_rdata_q <= 8'h00;
        end else begin
            eng_rdata_q <= buf_q[eng_idx_i];
            // Software writes take priority over the engine at the same byte.
            if (eng_wr_i) buf_q[eng_idx_i] <= eng_wdata_i;
            if (lin_data_acc && bus.wr) buf_q[idx] <= bus.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            uart_rx_q <= 8'h00;
            uart_tx_q <= 8'h00;
            uart_tx_load_q <= 1'b0;
        end else begin
            if (uart_rx_valid_i) uart_rx_q <= uart_rx_byte_i;
            uart_tx_load_q <= data_acc & bus.wr & uart_mode_i;
            if (data_acc && bus.wr && uart_mode_i) uart_tx_q <= bus.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            div_cnt_q <= 12'h000;
        end else if (div_cnt_q >= divisor) begin
            div_cnt_q <= 12'h000;
        end else begin
            div_cnt_q <= div_cnt_q + 12'h001;
        end
    end

    assign rdata_o = rdata_q;
    assign eng_rdata_o = eng_rdata_q;
    assign uart_tx_byte_o = uart_tx_q;
    assign uart_tx_load_o = uart_tx_load_q;
    assign error_summary_flag_o = summary;
    assign resync_disable_o = btr_q[lcr_pkg::BTR_RESYNC_BIT];
    assign samples_per_bit_o = btr_q[5:0];
    assign baud_divisor_o = divisor;
    assign sample_tick_o = div_cnt_q >= divisor;
    assign tx_response_length_o = uart_mode_i ? 4'h0 : (tx_raw > lcr_pkg::LEN_MAX ? lcr_pkg::LEN_MAX : tx_raw);
    assign rx_response_length_o = uart_mode_i ? 4'h0 : (rx_raw > lcr_pkg::LEN_MAX ? lcr_pkg::LEN_MAX : rx_raw);
    assign legacy_revision_select_o = legacy_q;
    assign frame_id_field_o = legacy_q ? {2'b00, idr_q[3:0]} : idr_q[5:0];
    assign identifier_parity_o = uart_mode_i ? 2'b00 : idr_q[7:6];
    assign legacy_response_length_o = (!legacy_q || uart_mode_i) ? 4'h0 :
        (legacy_response_length == 2'b11) ? 4'h8 : (legacy_response_length == 2'b10) ? 4'h4 : 4'h2;
endmodule : lcr_regs
`default_nettype wire

//--- lcr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lcr_checker (
    // Bus, error events and configuration.
    input wire logic clk_i, rstn_i, wr_i, rd_i, error_summary_flag_o,
    input wire logic [7:0] addr_i, wdata_i, rdata_o,
    input wire logic [3:0] tx_response_length_o, rx_response_length_o,
    input wire lcr_pkg::lcr_err_t err_set_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire clr = wr_i && addr_i == lcr_pkg::ADDR_STATUS && wdata_i[lcr_pkg::STATUS_ERR_BIT];
    property p_rise; $rose(error_summary_flag_o) |-> $past(|err_set_i); endproperty
    a_rise: assert property (p_rise) else $error("flag rose alone");
    property p_set; |err_set_i |=> error_summary_flag_o; endproperty
    a_set: assert property (p_set) else $error("event lost");
    property p_fall; $fell(error_summary_flag_o) |-> $past(clr); endproperty
    a_fall: assert property (p_fall) else $error("flag fell alone");
    property p_hold; error_summary_flag_o && !clr |=> error_summary_flag_o; endproperty
    a_hold: assert property (p_hold) else $error("flag dropped");
    property p_clr; clr && !(|err_set_i) |=> !error_summary_flag_o; endproperty
    a_clr: assert property (p_clr) else $error("clear ignored");
    property p_btr; rd_i && addr_i == lcr_pkg::ADDR_BTR |=> !rdata_o[6] && rdata_o[5:0] >= lcr_pkg::BTR_SPB_MIN;
    endproperty
    a_btr: assert property (p_btr) else $error("timing readback");
    property p_tx; tx_response_length_o <= lcr_pkg::LEN_MAX; endproperty
    a_tx: assert property (p_tx) else $error("tx length");
    property p_rx; rx_response_length_o <= lcr_pkg::LEN_MAX; endproperty
    a_rx: assert property (p_rx) else $error("rx length");
endmodule : lcr_checker
bind lcr_regs lcr_checker lcr_checker_i (.*);
`default_nettype wire

//--- lcr_partner.sv
`timescale 1ns/1ps
`default_nettype none
module lcr_partner (
    // Bench request and engine-side events.
    input wire logic clk_i, fire_i,
    input wire logic [2:0] cause_i,
    input wire logic [7:0] byte_i,
    output lcr_pkg::lcr_err_t err_set_o,
    output logic rx_valid_o,
    output logic [7:0] rx_byte_o
);
    // Between deliveries the byte lines toggle, so a stale byte is never taken for news.
    always_ff @(posedge clk_i) begin
        err_set_o <= fire_i ? lcr_pkg::lcr_err_t'(5'h01 << cause_i) : '0;
        rx_valid_o <= fire_i;
        rx_byte_o <= fire_i ? byte_i : ~rx_byte_o;
    end
endmodule : lcr_partner
`default_nettype wire

//--- tb_lcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_lcr_regs;
    logic clk_i = '0, rstn_i = '0, wr_i = '0, rd_i = '0, uart_mode_i = '0, fire = '0;
    logic [7:0] addr_i = '0, wdata_i = '0, byte_v = '0, rdata_o, uart_rx_byte_i, uart_tx_byte_o;
    logic [2:0] cause = '0;
    logic uart_rx_valid_i, uart_tx_load_o, error_summary_flag_o, resync_disable_o, sample_tick_o;
    logic [5:0] samples_per_bit_o, frame_id_field_o;
    logic [3:0] tx_response_length_o, rx_response_length_o, legacy_response_length_o;
    logic [11:0] baud_divisor_o;
    logic [1:0] identifier_parity_o;
    logic [7:0] eng_rdata_o;
    logic legacy_revision_select_o;
    lcr_pkg::lcr_err_t err_set_i;
    int err_total = 0, n_checks = 0, last = 0, gap = 0;
    always #12.5 clk_i = ~clk_i;
    lcr_partner lcr_partner_i (.clk_i, .fire_i(fire), .cause_i(cause), .byte_i(byte_v), .err_set_o(err_set_i),
        .rx_valid_o(uart_rx_valid_i), .rx_byte_o(uart_rx_byte_i));
    lcr_regs lcr_regs_i (.*, .eng_wr_i(fire), .eng_idx_i(cause), .eng_wdata_i(byte_v));
    task automatic chk(input logic [11:0] s, input logic [11:0] e);
        n_checks++;
        err_total += int'(s !== e);
        if (s !== e) $display("[ERR] %0t got %h want %h", $time, s, e);
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {addr_i, wdata_i, wr_i, rd_i} <= {a, d, w, !w};
        @(posedge clk_i);
        {wr_i, rd_i} <= 2'b00;
        #1 if (!w) chk(rdata_o, d);
    endtask : bus
    task automatic final_report();
        if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    task automatic t_timing();
        bus(1'b1, lcr_pkg::ADDR_BTR, 8'hff);
        chk(resync_disable_o, 1'b1);
        bus(1'b0, lcr_pkg::ADDR_BTR, 8'hbf);
        bus(1'b1, lcr_pkg::ADDR_BTR, 8'h05);
        chk({resync_disable_o, samples_per_bit_o}, 7'h08);
        bus(1'b1, lcr_pkg::ADDR_DIVL, 8'h03);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_i);
            #1 if (sample_tick_o) {gap, last} = {i - last, i};
        end
        chk(12'(gap), 12'h004);
        bus(1'b1, lcr_pkg::ADDR_DIVH, 8'h0a);
        chk(baud_divisor_o, 12'ha03);
        bus(1'b1, lcr_pkg::ADDR_LEN, 8'hc3);
        chk({tx_response_length_o, rx_response_length_o}, 8'h83);
    endtask : t_timing
    task automatic t_ident();
        bus(1'b1, lcr_pkg::ADDR_CTRL, 8'h40);
        chk(legacy_revision_select_o, 1'b1);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, lcr_pkg::ADDR_IDR, {2'b10, 2'(k), 4'h5});
            chk({identifier_parity_o, frame_id_field_o, legacy_response_length_o},
                {2'b10, 6'h05, 4'(k < 2 ? 2 : 2 << (k - 1))});
        end
        bus(1'b1, lcr_pkg::ADDR_CTRL, 8'h00);
        chk({frame_id_field_o, legacy_response_length_o}, 10'h350);
    endtask : t_ident
    task automatic t_errors();
        for (int k = 0; k < 5; k++) begin
            @(posedge clk_i);
            {cause, fire} <= {3'(k), 1'b1};
            @(posedge clk_i);
            fire <= 1'b0;
            bus(1'b1, lcr_pkg::ADDR_STATUS, 8'hf7);
            chk(error_summary_flag_o, 1'b1);
            bus(1'b0, lcr_pkg::ADDR_ERR, 8'(1 << k));
            bus(1'b1, lcr_pkg::ADDR_STATUS, 8'h08);
            bus(1'b0, lcr_pkg::ADDR_ERR, 8'h00);
        end
    endtask : t_errors
    task automatic t_data();
        bus(1'b1, lcr_pkg::ADDR_SEL, 8'h06);
        for (int k = 0; k < 3; k++) bus(1'b1, lcr_pkg::ADDR_DATA, 8'(8'ha0 + k));
        bus(1'b1, lcr_pkg::ADDR_SEL, 8'h06);
        for (int k = 0; k < 3; k++) bus(1'b0, lcr_pkg::ADDR_DATA, 8'(8'ha0 + k));
        bus(1'b1, lcr_pkg::ADDR_SEL, 8'h0e);
        repeat (2) bus(1'b0, lcr_pkg::ADDR_DATA, 8'ha0);
        @(posedge clk_i);
        {uart_mode_i, byte_v, fire} <= {1'b1, 8'h3c, 1'b1};
        @(posedge clk_i);
        fire <= 1'b0;
        bus(1'b0, lcr_pkg::ADDR_DATA, 8'h3c);
        bus(1'b1, lcr_pkg::ADDR_DATA, 8'h77);
        chk({uart_tx_load_o, uart_tx_byte_o}, 9'h177);
        chk({tx_response_length_o, rx_response_length_o}, 8'h00);
        chk(eng_rdata_o, 8'h3c);
    endtask : t_data
    initial begin
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        bus(1'b0, lcr_pkg::ADDR_BTR, 8'h20);
        bus(1'b0, 8'hff, 8'h00);
        t_timing();
        t_ident();
        t_errors();
        t_data();
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        bus(1'b0, lcr_pkg::ADDR_LEN, 8'h00);
        final_report();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        final_report();
    end
endmodule : tb_lcr_regs
`default_nettype wire
